// *** rtl/act_pkg.sv ***
// constants, register layouts and types of the compute and threshold control
// assumes a 32-bit apb master and a converter core on the same clock
// Behaviour
// - guard ring outputs start at the polarity bit level in precharge.
// - double sample pairs two conversions; compute only after the second.
// - at conversion start previous value loads filter output or result.
// - low-pass mode time constant is two to the shift, unity gain.
// - accumulate, average, burst average divide accumulator by two^shift.
// - basic mode ignores the shift field.
// - clear command empties accumulator, overflow, counter; bit self-clears.
// - mode field selects basic, accumulate, average, burst, low-pass.
// - continuous with stop set clears go on threshold, else retriggers.
// - continuous without stop never clears go; software must clear it.
// - without continuous run the stop bit has no effect.
// - threshold select picks the compare condition raising the event.
// - overflow flag set on accumulator or error overflow; software clears.
// - above-upper flag reads one when error exceeds upper threshold.
// - below-lower flag reads one when error is under lower threshold.
// - update flag set when computed values update; cleared by software.
// - stage status reports idle, first and second stage codes.
// - filter output is shifted accumulator, or low-pass result.
// - repeat counter counts computations; check when it reaches target.
`default_nettype none
package act_pkg;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_SAMPLE_CONTROL = 12'h0f54;
  localparam logic [11:0] IDX_COMPUTE_CONTROL = 12'h0f55;
  localparam logic [11:0] IDX_THRESHOLD_CONTROL = 12'h0f56;
  localparam logic [11:0] IDX_RUN_CONTROL = 12'h0f5b;
  localparam logic [11:0] IDX_PREVIOUS_VALUE = 12'h0f5c;
  localparam logic [11:0] IDX_CONVERSION_RESULT = 12'h0f5e;
  localparam logic [11:0] IDX_CONVERTER_STATUS = 12'h0f60;
  localparam logic [11:0] IDX_REPEAT_TARGET = 12'h0f61;
  localparam logic [11:0] IDX_REPEAT_COUNTER = 12'h0f62;
  localparam logic [11:0] IDX_SETPOINT = 12'h0f63;
  localparam logic [11:0] IDX_LOWER_THRESHOLD = 12'h0f65;
  localparam logic [11:0] IDX_UPPER_THRESHOLD = 12'h0f67;
  localparam logic [11:0] IDX_ERROR_VALUE = 12'h0f69;
  localparam logic [11:0] IDX_ACCUMULATOR = 12'h0f6b;
  localparam logic [11:0] IDX_FILTER_OUTPUT = 12'h0f6d;
  // reset values
  localparam logic [7:0] RST_CTRL8 = 8'h00;
  localparam logic [15:0] RST_WORD16 = 16'h0000;
  // compute mode codes
  localparam logic [2:0] MODE_BASIC = 3'h0;
  localparam logic [2:0] MODE_ACCUMULATE = 3'h1;
  localparam logic [2:0] MODE_AVERAGE = 3'h2;
  localparam logic [2:0] MODE_BURST = 3'h3;
  localparam logic [2:0] MODE_LOWPASS = 3'h4;
  // stage status codes
  localparam logic [2:0] STAGE_IDLE = 3'h0;
  localparam logic [2:0] STAGE_PRE1 = 3'h1;
  localparam logic [2:0] STAGE_ACQ1 = 3'h2;
  localparam logic [2:0] STAGE_CONV1 = 3'h3;
  localparam logic [2:0] STAGE_PRE2 = 3'h5;
  localparam logic [2:0] STAGE_ACQ2 = 3'h6;
  localparam logic [2:0] STAGE_CONV2 = 3'h7;

  typedef struct packed {
    logic [1:0] unused_7_6;
    logic guard_ring_polarity;
    logic [3:0] unused_4_1;
    logic double_sample_enable;
  } act_sample_ctrl_type;

  typedef struct packed {
    logic previous_sample_select;
    logic [2:0] accumulate_shift;
    logic accumulator_clear;
    logic [2:0] compute_mode_select;
  } act_compute_ctrl_type;

  typedef struct packed {
    logic unused_7;
    logic [2:0] error_calc_select;
    logic stop_on_threshold;
    logic [2:0] threshold_event_select;
  } act_threshold_ctrl_type;

  typedef struct packed {
    logic unused_7;
    logic continuous_run;
    logic unused_5;
    logic clock_source_select;
    logic [2:0] unused_3_1;
    logic conversion_go;
  } act_run_ctrl_type;

  typedef struct packed {
    logic accumulator_overflow;
    logic above_upper_flag;
    logic below_lower_flag;
    logic compute_update_flag;
    logic unused_3;
    logic [2:0] stage_status;
  } act_status_type;

  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE1, ST_ACQ1, ST_CONV1, ST_PRE2, ST_ACQ2, ST_CONV2
  } act_stage_type;
endpackage : act_pkg
`default_nettype wire

// *** rtl/act_compute_ctrl.sv ***
// compute stage control: registers, stage sequencer, accumulator, thresholds
// assumes the converter core shares core_clk and pulses core_stage_done at
// the end of each precharge, acquisition and conversion stage
`default_nettype none
module act_compute_ctrl #(
  parameter int unsigned PADDR_W = 14,
  parameter int unsigned RESULT_W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter core
  input wire logic core_stage_done,
  input wire logic [RESULT_W-1:0] core_result,
  output logic conv_start,
  output logic guard_ring_out,
  output logic threshold_event
);
  if (PADDR_W < 14 || RESULT_W > 16 || RESULT_W < 1) begin : g_chk
    $error("act_compute_ctrl: unsupported parameter values");
  end

  localparam act_pkg::act_stage_type ST_IDLE = act_pkg::ST_IDLE;
  localparam act_pkg::act_stage_type ST_PRE1 = act_pkg::ST_PRE1;
  localparam act_pkg::act_stage_type ST_ACQ1 = act_pkg::ST_ACQ1;
  localparam act_pkg::act_stage_type ST_CONV1 = act_pkg::ST_CONV1;
  localparam act_pkg::act_stage_type ST_PRE2 = act_pkg::ST_PRE2;
  localparam act_pkg::act_stage_type ST_ACQ2 = act_pkg::ST_ACQ2;
  localparam act_pkg::act_stage_type ST_CONV2 = act_pkg::ST_CONV2;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  act_pkg::act_sample_ctrl_type sc_q, sc_d;
  act_pkg::act_compute_ctrl_type cc_q, cc_d;
  act_pkg::act_threshold_ctrl_type tc_q, tc_d;
  act_pkg::act_run_ctrl_type rc_q, rc_d;
  act_pkg::act_stage_type state_q, state_d;
  logic aov_q, aov_d, above_q, above_d, below_q, below_d, upd_q, upd_d;
  logic [7:0] tgt_q, tgt_d, cnt_q, cnt_d;
  logic [15:0] prev_q, prev_d, res_q, res_d, acc_q, acc_d, filt_q, filt_d;
  logic [15:0] err_q, err_d, setp_q, setp_d, lower_q, lower_d;
  logic [15:0] upper_q, upper_d;
  logic start_q, start_d, guard_q, guard_d, evt_q, evt_d;

  logic [11:0] idx;
  logic access, wr;
  assign idx = paddr[13:2];
  assign access = psel & penable & pready_q;
  assign wr = access & pwrite;

  function automatic logic wr_hit(input logic [11:0] r, input logic lane);
    return wr && idx == r && lane;
  endfunction

  function automatic logic [2:0] stage_code(input act_pkg::act_stage_type s);
    unique case (s)
      ST_IDLE: stage_code = act_pkg::STAGE_IDLE;
      ST_PRE1: stage_code = act_pkg::STAGE_PRE1;
      ST_ACQ1: stage_code = act_pkg::STAGE_ACQ1;
      ST_CONV1: stage_code = act_pkg::STAGE_CONV1;
      ST_PRE2: stage_code = act_pkg::STAGE_PRE2;
      ST_ACQ2: stage_code = act_pkg::STAGE_ACQ2;
      ST_CONV2: stage_code = act_pkg::STAGE_CONV2;
    endcase
  endfunction

  function automatic logic thr_hit(input logic [2:0] sel, input logic gt_u,
                                   input logic lt_l, input logic gt_l,
                                   input logic lt_u);
    unique case (sel)
      3'h7: thr_hit = 1'b1;
      3'h6: thr_hit = gt_u;
      3'h5: thr_hit = ~gt_u;
      3'h4: thr_hit = lt_l | gt_u;
      3'h3: thr_hit = gt_l & lt_u;
      3'h2: thr_hit = ~lt_l;
      3'h1: thr_hit = lt_l;
      3'h0: thr_hit = 1'b0;
    endcase
  endfunction

  // status view; read-only fields come from state, never from the bus
  act_pkg::act_status_type status;
  assign status = '{accumulator_overflow: aov_q, above_upper_flag: above_q,
                    below_lower_flag: below_q, compute_update_flag: upd_q,
                    unused_3: 1'b0, stage_status: stage_code(state_q)};

  // apb: one wait state, data and error registered with pready
  always_comb begin
    pready_d = psel & penable & ~pready_q;
    pslverr_d = 1'b0;
    prdata_d = prdata_q;
    if (pready_d) begin
      prdata_d = 32'h0000_0000;
      case (idx)
        act_pkg::IDX_SAMPLE_CONTROL: prdata_d[7:0] = sc_q;
        act_pkg::IDX_COMPUTE_CONTROL: prdata_d[7:0] = cc_q;
        act_pkg::IDX_THRESHOLD_CONTROL: prdata_d[7:0] = tc_q;
        act_pkg::IDX_RUN_CONTROL: prdata_d[7:0] = rc_q;
        act_pkg::IDX_PREVIOUS_VALUE: prdata_d[15:0] = prev_q;
        act_pkg::IDX_CONVERSION_RESULT: prdata_d[15:0] = res_q;
        act_pkg::IDX_CONVERTER_STATUS: prdata_d[7:0] = status;
        act_pkg::IDX_REPEAT_TARGET: prdata_d[7:0] = tgt_q;
        act_pkg::IDX_REPEAT_COUNTER: prdata_d[7:0] = cnt_q;
        act_pkg::IDX_SETPOINT: prdata_d[15:0] = setp_q;
        act_pkg::IDX_LOWER_THRESHOLD: prdata_d[15:0] = lower_q;
        act_pkg::IDX_UPPER_THRESHOLD: prdata_d[15:0] = upper_q;
        act_pkg::IDX_ERROR_VALUE: prdata_d[15:0] = err_q;
        act_pkg::IDX_ACCUMULATOR: prdata_d[15:0] = acc_q;
        act_pkg::IDX_FILTER_OUTPUT: prdata_d[15:0] = filt_q;
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {pready_q, pslverr_q} <= 2'b00;
      prdata_q <= 32'h0000_0000;
    end else begin
      {pready_q, pslverr_q, prdata_q} <= {pready_d, pslverr_d, prdata_d};
    end
  end

  // computation datapath
  logic [15:0] res16, filt_new, err_new;
  logic [16:0] sum17, lpf17, acc17, diff17;
  logic [7:0] cnt_new;
  logic conv_end, compute_now, is_sum, is_lpf, is_avg, check, ovf_now;
  logic gt_u, lt_l, gt_l, lt_u, evt_now;
  logic [2:0] shift;

  assign shift = cc_q.accumulate_shift;
  assign res16 = 16'(core_result);
  assign is_lpf = cc_q.compute_mode_select == act_pkg::MODE_LOWPASS;
  assign is_avg = cc_q.compute_mode_select == act_pkg::MODE_AVERAGE ||
                  cc_q.compute_mode_select == act_pkg::MODE_BURST;
  assign is_sum = is_avg ||
                  cc_q.compute_mode_select == act_pkg::MODE_ACCUMULATE;
  assign conv_end = core_stage_done &&
                    (state_q == ST_CONV1 || state_q == ST_CONV2);
  assign compute_now = core_stage_done && (state_q == ST_CONV2 ||
    (state_q == ST_CONV1 && !sc_q.double_sample_enable));
  assign sum17 = {1'b0, acc_q} + {1'b0, res16};
  // leaky integrator: acc keeps 2^shift times the output, so gain is one
  assign lpf17 = {1'b0, acc_q} - 17'(acc_q >> shift) + 17'(res16);
  // reserved mode codes behave as basic
  assign acc17 = is_lpf ? lpf17 : (is_sum ? sum17 : {1'b0, acc_q});
  assign filt_new = (is_lpf || is_sum) ? (acc17[15:0] >> shift)
                                       : filt_q;
  assign diff17 = tc_q.error_calc_select[0] ?
                  {1'b0, filt_new} - {1'b0, setp_q} :
                  {1'b0, res16} - {1'b0, prev_q};
  assign err_new = diff17[15:0];
  assign ovf_now = compute_now &&
                   (acc17[16] || (diff17[16] ^ diff17[15]));
  assign cnt_new = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
  assign check = (is_avg || is_lpf) ? (cnt_new >= tgt_q) : 1'b1;
  assign gt_u = $signed(err_new) > $signed(upper_q);
  assign lt_l = $signed(err_new) < $signed(lower_q);
  assign gt_l = $signed(err_new) > $signed(lower_q);
  assign lt_u = $signed(err_new) < $signed(upper_q);
  assign evt_now = compute_now && check &&
    thr_hit(tc_q.threshold_event_select, gt_u, lt_l, gt_l, lt_u);

  always_comb begin
    logic retrig;
    retrig = 1'b0;
    sc_d = sc_q;
    cc_d = cc_q;
    tc_d = tc_q;
    rc_d = rc_q;
    state_d = state_q;
    {aov_d, above_d, below_d, upd_d} = {aov_q, above_q, below_q, upd_q};
    {tgt_d, cnt_d} = {tgt_q, cnt_q};
    {prev_d, res_d, acc_d, filt_d, err_d} =
      {prev_q, res_q, acc_q, filt_q, err_q};
    {setp_d, lower_d, upper_d} = {setp_q, lower_q, upper_q};
    start_d = 1'b0;
    evt_d = evt_now;
    // stage sequencer
    unique case (state_q)
      ST_IDLE: if (rc_q.conversion_go) begin
        state_d = ST_PRE1;
        start_d = 1'b1;
      end
      ST_PRE1: if (core_stage_done) state_d = ST_ACQ1;
      ST_ACQ1: if (core_stage_done) state_d = ST_CONV1;
      ST_CONV1: if (core_stage_done) begin
        state_d = sc_q.double_sample_enable ? ST_PRE2 : ST_IDLE;
      end
      ST_PRE2: if (core_stage_done) state_d = ST_ACQ2;
      ST_ACQ2: if (core_stage_done) state_d = ST_CONV2;
      ST_CONV2: if (core_stage_done) state_d = ST_IDLE;
    endcase
    if (conv_end) res_d = res16;
    if (compute_now) begin
      upd_d = 1'b1;
      err_d = err_new;
      acc_d = acc17[15:0];
      filt_d = filt_new;
      cnt_d = cnt_new;
      if (check) begin
        above_d = gt_u;
        below_d = lt_l;
        if (is_avg || is_lpf) cnt_d = 8'h00;
        if (is_avg) acc_d = 16'h0000;
      end
      // burst repeats inside one trigger until the count is reached
      if (cc_q.compute_mode_select == act_pkg::MODE_BURST && !check) begin
        retrig = 1'b1;
      end else if (rc_q.continuous_run) begin
        if (tc_q.stop_on_threshold && evt_now) begin
          rc_d.conversion_go = 1'b0;
        end else begin
          retrig = rc_q.conversion_go;
        end
      end else begin
        rc_d.conversion_go = 1'b0;
      end
      if (retrig) begin
        state_d = ST_PRE1;
        start_d = 1'b1;
      end
    end
    if (start_d) begin
      prev_d = cc_q.previous_sample_select ? filt_q : res_q;
    end
    // clear command takes one cycle, then the bit drops by itself
    if (cc_q.accumulator_clear) begin
      acc_d = 16'h0000;
      cnt_d = 8'h00;
      aov_d = 1'b0;
      cc_d.accumulator_clear = 1'b0;
    end
    // software writes; a go set here wins over the hardware clear above
    if (wr_hit(act_pkg::IDX_SAMPLE_CONTROL, pstrb[0])) begin
      sc_d = act_pkg::act_sample_ctrl_type'(pwdata[7:0]);
      sc_d.unused_7_6 = 2'b00;
      sc_d.unused_4_1 = 4'h0;
    end
    if (wr_hit(act_pkg::IDX_COMPUTE_CONTROL, pstrb[0])) begin
      cc_d = act_pkg::act_compute_ctrl_type'(pwdata[7:0]);
      cc_d.accumulator_clear = pwdata[3] | cc_d.accumulator_clear;
    end
    if (wr_hit(act_pkg::IDX_THRESHOLD_CONTROL, pstrb[0])) begin
      tc_d = act_pkg::act_threshold_ctrl_type'(pwdata[7:0]);
      tc_d.unused_7 = 1'b0;
    end
    if (wr_hit(act_pkg::IDX_RUN_CONTROL, pstrb[0])) begin
      rc_d = act_pkg::act_run_ctrl_type'(pwdata[7:0]);
      {rc_d.unused_7, rc_d.unused_5, rc_d.unused_3_1} = 5'h00;
    end
    if (wr_hit(act_pkg::IDX_REPEAT_TARGET, pstrb[0])) tgt_d = pwdata[7:0];
    if (wr_hit(act_pkg::IDX_SETPOINT, pstrb[0])) setp_d[7:0] = pwdata[7:0];
    if (wr_hit(act_pkg::IDX_SETPOINT, pstrb[1])) setp_d[15:8] = pwdata[15:8];
    if (wr_hit(act_pkg::IDX_LOWER_THRESHOLD, pstrb[0])) begin
      lower_d[7:0] = pwdata[7:0];
    end
    if (wr_hit(act_pkg::IDX_LOWER_THRESHOLD, pstrb[1])) begin
      lower_d[15:8] = pwdata[15:8];
    end
    if (wr_hit(act_pkg::IDX_UPPER_THRESHOLD, pstrb[0])) begin
      upper_d[7:0] = pwdata[7:0];
    end
    if (wr_hit(act_pkg::IDX_UPPER_THRESHOLD, pstrb[1])) begin
      upper_d[15:8] = pwdata[15:8];
    end
    // status: write one clears the two clearable flags, set still wins;
    // the stage code and threshold flags ignore writes
    if (wr_hit(act_pkg::IDX_CONVERTER_STATUS, pstrb[0])) begin
      if (pwdata[7] && !ovf_now) aov_d = 1'b0;
      if (pwdata[4] && !compute_now) upd_d = 1'b0;
    end
    if (ovf_now) aov_d = 1'b1;
    // guard ring: polarity level in precharge, inverted while sampling
    unique case (state_d)
      ST_ACQ1, ST_CONV1, ST_ACQ2, ST_CONV2:
        guard_d = ~sc_d.guard_ring_polarity;
      default: guard_d = sc_d.guard_ring_polarity;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      {sc_q, cc_q, tc_q, rc_q} <= {4{act_pkg::RST_CTRL8}};
      state_q <= ST_IDLE;
      {aov_q, above_q, below_q, upd_q} <= 4'h0;
      {tgt_q, cnt_q} <= {2{act_pkg::RST_CTRL8}};
      {prev_q, res_q, acc_q, filt_q} <= {4{act_pkg::RST_WORD16}};
      {err_q, setp_q, lower_q, upper_q} <= {4{act_pkg::RST_WORD16}};
      {start_q, guard_q, evt_q} <= 3'h0;
    end else begin
      {sc_q, cc_q, tc_q, rc_q} <= {sc_d, cc_d, tc_d, rc_d};
      state_q <= state_d;
      {aov_q, above_q, below_q, upd_q} <= {aov_d, above_d, below_d, upd_d};
      {tgt_q, cnt_q} <= {tgt_d, cnt_d};
      {prev_q, res_q, acc_q, filt_q} <= {prev_d, res_d, acc_d, filt_d};
      {err_q, setp_q, lower_q, upper_q} <= {err_d, setp_d, lower_d, upper_d};
      {start_q, guard_q, evt_q} <= {start_d, guard_d, evt_d};
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign conv_start = start_q;
  assign guard_ring_out = guard_q;
  assign threshold_event = evt_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_stop_on_hit: assert property (
    compute_now && evt_now && rc_q.continuous_run && tc_q.stop_on_threshold
    && cc_q.compute_mode_select != act_pkg::MODE_BURST
    && !wr_hit(act_pkg::IDX_RUN_CONTROL, pstrb[0])
    |=> !rc_q.conversion_go && state_q == ST_IDLE)
    else $error("go not cleared on threshold stop");
  a_go_kept_cont: assert property (
    compute_now && rc_q.continuous_run && rc_q.conversion_go
    && !tc_q.stop_on_threshold && !wr
    |=> rc_q.conversion_go && state_q == ST_PRE1 && start_q)
    else $error("continuous run lost go without stop");
  a_single_clears: assert property (
    compute_now && !rc_q.continuous_run && !wr
    && cc_q.compute_mode_select != act_pkg::MODE_BURST
    |=> !rc_q.conversion_go && state_q == ST_IDLE)
    else $error("single conversion kept go");
  a_clear_cmd: assert property (
    cc_q.accumulator_clear && !wr
    |=> acc_q == 16'h0000 && cnt_q == 8'h00 && !cc_q.accumulator_clear)
    else $error("accumulator clear did not complete");
  a_pair_compute: assert property (
    state_q == ST_CONV1 && core_stage_done && sc_q.double_sample_enable
    |-> !compute_now ##1 state_q == ST_PRE2)
    else $error("computed after first of a pair");
  a_prev_load: assert property (
    start_d |=> prev_q == ($past(cc_q.previous_sample_select) ?
                           $past(filt_q) : $past(res_q)))
    else $error("previous value loaded from wrong source");
  a_guard_pre: assert property (
    (state_q == ST_PRE1 || state_q == ST_PRE2)
    |-> guard_ring_out == sc_q.guard_ring_polarity ||
        $past(wr_hit(act_pkg::IDX_SAMPLE_CONTROL, pstrb[0])))
    else $error("guard ring wrong in precharge");
  a_upper_flag: assert property (
    compute_now && check |=> above_q == ($signed(err_q) > $signed(upper_q))
      || $past(wr_hit(act_pkg::IDX_UPPER_THRESHOLD, 1'b1)))
    else $error("above-upper flag wrong");
  a_ovf_sticky: assert property (
    ovf_now |=> aov_q)
    else $error("overflow flag not set");
  a_upd_set: assert property (
    compute_now |=> upd_q)
    else $error("update flag not set");
  a_stage_code: assert property (
    state_q == ST_CONV2 |-> status.stage_status == act_pkg::STAGE_CONV2)
    else $error("stage code wrong");
  a_apb_answer: assert property (
    psel && penable && !pready_q |=> pready_q ##1 !pready_q)
    else $error("apb answer timing wrong");

  c_double_pair: cover property (
    state_q == ST_CONV2 && compute_now);
  c_stop_event: cover property (
    evt_now && rc_q.continuous_run && tc_q.stop_on_threshold);
  c_overflow: cover property (ovf_now);
  c_lowpass_check: cover property (compute_now && is_lpf && check);
endmodule // act_compute_ctrl
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench of the compute and threshold control
// assumes one apb wait state and a converter core driven by the bench
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, sys_rst, psel, penable, pwrite, pready, pslverr, slv;
  logic core_stage_done, conv_start, guard_ring_out, threshold_event;
  logic ev, st, g;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [9:0] core_result, res, prev;
  int num_errors, comparisons, e;
  int dl[4] = '{5, 10, 20, 25};
  act_compute_ctrl u_act_compute_ctrl (.core_clk(core_clk),
    .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_stage_done(core_stage_done),
    .core_result(core_result), .conv_start(conv_start),
    .guard_ring_out(guard_ring_out), .threshold_event(threshold_event));
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("mismatches %0d compares %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic hang(input int n);
    if (n >= 40) begin
      num_errors++;
      $display("BAD %0t no answer", $time);
      end_sim();
    end
  endtask
  // request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] idx,
                     input logic [31:0] wd);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    hang(n);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_start;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
      g = guard_ring_out;
    end while (conv_start !== 1'b1 && n < 40);
    hang(n);
  endtask
  // stage ends from the core, then watch for event and retrigger
  task automatic pulse(input int k, input logic [9:0] r);
    for (int i = 0; i < k; i++) begin
      @(posedge core_clk);
      core_stage_done <= 1'b1;
      core_result <= r;
      @(posedge core_clk);
      core_stage_done <= 1'b0;
    end
    ev = 1'b0;
    st = 1'b0;
    repeat (3) begin
      @(posedge core_clk);
      ev = ev | (threshold_event === 1'b1);
      st = st | (conv_start === 1'b1);
    end
  endtask
  task automatic go_conv(input logic [9:0] r);
    apb(1, act_pkg::IDX_RUN_CONTROL, 32'h0000_0001);
    wait_start();
    pulse(3, r);
  endtask
  function automatic logic hit(input logic [2:0] s, input int x);
    case (s)
      3'h7: hit = 1'b1;
      3'h6: hit = x > 20;
      3'h5: hit = x <= 20;
      3'h4: hit = x < 10 || x > 20;
      3'h3: hit = x > 10 && x < 20;
      3'h2: hit = x >= 10;
      3'h1: hit = x < 10;
      default: hit = 1'b0;
    endcase
  endfunction
  task automatic t_reset;
    apb(0, act_pkg::IDX_COMPUTE_CONTROL, 0);
    check(rd, 32'h0000_0000);
    apb(0, act_pkg::IDX_THRESHOLD_CONTROL, 0);
    check(rd, 32'h0000_0000);
    apb(0, act_pkg::IDX_CONVERTER_STATUS, 0);
    check(rd, 32'h0000_0000);
    apb(0, 12'h0f70, 0);
    check(slv, 1'b1);
    check(rd, 32'h0000_0000);
    $display("reset test done");
  endtask
  task automatic t_single;
    apb(1, act_pkg::IDX_SAMPLE_CONTROL, 32'h0000_0020);
    apb(1, act_pkg::IDX_THRESHOLD_CONTROL, 32'h0000_0007);
    apb(1, act_pkg::IDX_RUN_CONTROL, 32'h0000_0001);
    wait_start();
    check(g, 1'b1);
    pulse(1, 0);
    apb(0, act_pkg::IDX_CONVERTER_STATUS, 0);
    check(rd[2:0], act_pkg::STAGE_ACQ1);
    check(guard_ring_out, 1'b0);
    pulse(2, 10'h064);
    check({ev, st}, 2'b10);
    apb(0, act_pkg::IDX_RUN_CONTROL, 0);
    check(rd, 32'h0000_0000);
    apb(0, act_pkg::IDX_CONVERTER_STATUS, 0);
    check(rd, 32'h0000_0050);
    apb(1, act_pkg::IDX_CONVERTER_STATUS, 32'h0000_00ff);
    apb(0, act_pkg::IDX_CONVERTER_STATUS, 0);
    check(rd, 32'h0000_0040);
    $display("single test done");
  endtask
  task automatic t_table;
    prev = 10'h064;
    apb(1, act_pkg::IDX_LOWER_THRESHOLD, 32'h0000_000a);
    apb(1, act_pkg::IDX_UPPER_THRESHOLD, 32'h0000_0014);
    for (int i = 0; i < 32; i++) begin
      e = dl[i % 4];
      res = prev + e[9:0];
      apb(1, act_pkg::IDX_THRESHOLD_CONTROL, {29'd0, 3'(i / 4)});
      go_conv(res);
      check(ev, hit(3'(i / 4), e));
      apb(0, act_pkg::IDX_CONVERTER_STATUS, 0);
      check(rd[6:5], {e > 20, e < 10});
      prev = res;
    end
    $display("threshold test done");
  endtask
  task automatic t_double;
    apb(1, act_pkg::IDX_SAMPLE_CONTROL, 32'h0000_0021);
    apb(1, act_pkg::IDX_THRESHOLD_CONTROL, 32'h0000_0007);
    go_conv(10'h010);
    check(ev, 1'b0);
    apb(0, act_pkg::IDX_CONVERTER_STATUS, 0);
    check(rd[2:0], act_pkg::STAGE_PRE2);
    pulse(3, 10'h020);
    check(ev, 1'b1);
    apb(1, act_pkg::IDX_SAMPLE_CONTROL, 32'h0000_0020);
    $display("double test done");
  endtask
  task automatic t_cont;
    apb(1, act_pkg::IDX_RUN_CONTROL, 32'h0000_0041);
    wait_start();
    pulse(3, 10'h030);
    check(st, 1'b1);
    apb(1, act_pkg::IDX_RUN_CONTROL, 32'h0000_0040);
    pulse(3, 10'h030);
    check(st, 1'b0);
    apb(1, act_pkg::IDX_THRESHOLD_CONTROL, 32'h0000_000f);
    apb(1, act_pkg::IDX_RUN_CONTROL, 32'h0000_0041);
    wait_start();
    pulse(3, 10'h030);
    apb(0, act_pkg::IDX_RUN_CONTROL, 0);
    check(st, 1'b0);
    check(rd, 32'h0000_0040);
    apb(1, act_pkg::IDX_RUN_CONTROL, 32'h0000_0000);
    $display("continuous test done");
  endtask
  task automatic t_acc;
    apb(1, act_pkg::IDX_THRESHOLD_CONTROL, 32'h0000_0000);
    apb(1, act_pkg::IDX_COMPUTE_CONTROL, 32'h0000_0019);
    go_conv(10'h064);
    go_conv(10'h032);
    apb(0, act_pkg::IDX_ACCUMULATOR, 0);
    check(rd, 32'h0000_0096);
    apb(0, act_pkg::IDX_FILTER_OUTPUT, 0);
    check(rd, 32'h0000_004b);
    apb(1, act_pkg::IDX_COMPUTE_CONTROL, 32'h0000_0019);
    apb(0, act_pkg::IDX_COMPUTE_CONTROL, 0);
    check(rd, 32'h0000_0011);
    apb(0, act_pkg::IDX_ACCUMULATOR, 0);
    check(rd, 32'h0000_0000);
    $display("accumulate test done");
  endtask
  task automatic t_avg;
    apb(1, act_pkg::IDX_THRESHOLD_CONTROL, 32'h0000_0007);
    apb(1, act_pkg::IDX_REPEAT_TARGET, 32'h0000_0002);
    apb(1, act_pkg::IDX_COMPUTE_CONTROL, 32'h0000_0092);
    go_conv(10'h064);
    check(ev, 1'b0);
    go_conv(10'h032);
    check(ev, 1'b1);
    apb(0, act_pkg::IDX_PREVIOUS_VALUE, 0);
    check(rd, 32'h0000_0032);
    apb(0, act_pkg::IDX_FILTER_OUTPUT, 0);
    check(rd, 32'h0000_004b);
    apb(0, act_pkg::IDX_REPEAT_COUNTER, 0);
    check(rd, 32'h0000_0000);
    $display("average test done");
  endtask
  initial begin
    {sys_rst, psel, penable, pwrite, core_stage_done} = 5'b10000;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'hf;
    core_result = '0;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_single();
    t_table();
    t_double();
    t_cont();
    t_acc();
    t_avg();
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
